// ---- hdl/hpf_front.sv ----
// Purpose: Host port cycle front end: strobe, latch, decode, ready, DMA
// Assumes: 32-bit host words; DMA memory answers with a one-cycle ack
// Notes:   Host pins pass a two-stage synchroniser first
`include "hpf_consts.svh"
`default_nettype none
module hpf_front #(
   parameter int AW = 32
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Host pins
   input  wire logic          chip_select_n,
   input  wire logic          data_strobe_a,
   input  wire logic          data_strobe_b,
   input  wire logic          addr_strobe_n,
   input  wire logic [1:0]    cycle_select,
   input  wire logic          read_write_select,
   input  wire logic [31:0]   host_data_in,
   output var  logic [31:0]   host_data_out,
   output var  logic          host_data_oe_n,
   output var  logic          host_ready,
   // Local CPU control
   input  wire logic          port_reset_bit,
   // Control register image
   output var  logic          halfword_order_bit,
   output var  logic          dual_address_mode_bit,
   output var  logic          address_select_bit,
   // DMA memory path
   output var  logic          mem_req,
   output var  logic          mem_we,
   output var  logic [AW-1:0] mem_addr,
   output var  logic [31:0]   mem_wdata,
   input  wire logic          mem_ack,
   input  wire logic [31:0]   mem_rdata
);
   // ***************************************
   // Synchronised host pins
   // ***************************************
   logic        cs_n_s;        // Chip select, synced
   logic        ds_a_s;        // Strobe A, synced
   logic        ds_b_s;        // Strobe B, synced
   logic        as_n_s;        // Address strobe, synced
   hpf_pkg::hpf_ctl_t pin_ctl_s; // Cycle control, synced
   logic [31:0] data_s;        // Data bus, synced

   hpf_sync #(.W(39), .INIT({4'hf, 35'h0})) hpf_sync_inst (
      .clk     (clk),
      .reset_n (reset_n),
      .d       ({chip_select_n, data_strobe_a, data_strobe_b, addr_strobe_n,
                 cycle_select, read_write_select, host_data_in}),
      .q       ({cs_n_s, ds_a_s, ds_b_s, as_n_s, pin_ctl_s, data_s})
   );

   // ***************************************
   // Strobe derivation and edges
   // ***************************************
   logic strobe_low;                // Internal strobe active
   logic strobe_prev_reg;           // Strobe one cycle back
   logic as_prev_reg;               // Address strobe one cycle back
   wire  cs_low     = ~cs_n_s;      // Port selected
   assign strobe_low = cs_low & (ds_a_s ^ ds_b_s);
   wire  strobe_fall = strobe_low & ~strobe_prev_reg;
   wire  strobe_rise = ~strobe_low & strobe_prev_reg;
   wire  as_fall     = ~as_n_s & as_prev_reg;

   // ***************************************
   // Registers
   // ***************************************
   hpf_pkg::hpf_state_t state_reg, state_next;  // Cycle state
   hpf_pkg::hpf_ctl_t   ctl_reg;                // Latched control
   logic                as_held_reg;            // Control taken by address strobe
   logic [AW-1:0]       rd_addr_reg;            // Read address register
   logic [AW-1:0]       wr_addr_reg;            // Write address register
   logic [31:0]         data_reg;               // Port data register

   // Decode of the latched cycle
   wire is_ctrl  = ctl_reg.cyc == `HPF_CS_CTRL;
   wire is_addr  = ctl_reg.cyc == `HPF_CS_ADDR;
   wire is_inc   = ctl_reg.cyc == `HPF_CS_DATA_INC;
   wire is_data  = ctl_reg.cyc[0];
   wire wr_end   = (state_reg == hpf_pkg::S_HOLD) & strobe_rise & ~ctl_reg.rd;
   // Start one edge after the strobe fall, once ctl_reg holds the new cycle
   wire start    = (state_reg == hpf_pkg::S_IDLE) & strobe_low & strobe_prev_reg & ~port_reset_bit;
   wire fetch_ok = (state_reg == hpf_pkg::S_FETCH) & mem_ack;
   wire store_ok = (state_reg == hpf_pkg::S_STORE) & mem_ack;

   // Address register write targets
   wire sel_rd   = ~dual_address_mode_bit | address_select_bit;
   wire sel_wr   = ~dual_address_mode_bit | ~address_select_bit;

   // Control register image for host reads
   logic [31:0] ctrl_image;
   always_comb begin
      ctrl_image = 32'h0;
      ctrl_image[`HPF_CTL_HALF_BIT]    = halfword_order_bit;
      ctrl_image[`HPF_CTL_DUAL_BIT]    = dual_address_mode_bit;
      ctrl_image[`HPF_CTL_ARWSEL_BIT]  = address_select_bit;
      ctrl_image[`HPF_CTL_RST_BIT]     = port_reset_bit;
      ctrl_image[`HPF_CTL_HALF_MIRROR] = halfword_order_bit;
   end

   // Address register shown to the host
   wire [31:0] addr_image = 32'(sel_rd ? rd_addr_reg : wr_addr_reg);

   // ***************************************
   // Next state
   // ***************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         hpf_pkg::S_IDLE: begin
            if (start) begin
               state_next = (ctl_reg.rd && is_data) ? hpf_pkg::S_FETCH : hpf_pkg::S_HOLD;
            end
         end
         hpf_pkg::S_FETCH: begin
            if (mem_ack) begin
               state_next = hpf_pkg::S_HOLD;
            end
         end
         hpf_pkg::S_HOLD: begin
            if (strobe_rise) begin
               state_next = (~ctl_reg.rd && is_data) ? hpf_pkg::S_STORE : hpf_pkg::S_IDLE;
            end
         end
         hpf_pkg::S_STORE: begin
            if (mem_ack) begin
               state_next = hpf_pkg::S_IDLE;
            end
         end
         default: state_next = hpf_pkg::S_IDLE;
      endcase
   end

   // Busy resources hold the host off
   wire busy       = port_reset_bit | (state_next == hpf_pkg::S_FETCH)
                   | (state_next == hpf_pkg::S_STORE);
   wire ready_next = cs_low & busy;

   // ***************************************
   // State, edges and ready
   // ***************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg       <= hpf_pkg::S_IDLE;
         strobe_prev_reg <= 1'b0;
         as_prev_reg     <= 1'b1;
         host_ready      <= 1'b0;
      end else begin
         state_reg       <= state_next;
         strobe_prev_reg <= strobe_low;
         as_prev_reg     <= as_n_s;
         host_ready      <= ready_next;
      end
   end

   // ***************************************
   // Control latch: address strobe first, else strobe fall
   // ***************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_reg     <= '0;
         as_held_reg <= 1'b0;
      end else begin
         if (as_fall) begin
            ctl_reg     <= pin_ctl_s;
            as_held_reg <= 1'b1;
         end else if (strobe_fall && !as_held_reg) begin
            ctl_reg <= pin_ctl_s;
         end else if (strobe_rise) begin
            as_held_reg <= 1'b0;
         end
      end
   end

   // ***************************************
   // Control and address registers
   // ***************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         halfword_order_bit    <= 1'b0;
         dual_address_mode_bit <= 1'b0;
         address_select_bit    <= 1'b0;
         rd_addr_reg           <= AW'(`HPF_ADDR_RESET);
         wr_addr_reg           <= AW'(`HPF_ADDR_RESET);
      end else begin
         // Host control write
         if (wr_end && is_ctrl) begin
            halfword_order_bit    <= data_s[`HPF_CTL_HALF_BIT];
            dual_address_mode_bit <= data_s[`HPF_CTL_DUAL_BIT];
            address_select_bit    <= data_s[`HPF_CTL_ARWSEL_BIT];
         end
         // Host address write, or post-increment after a read or a write
         if (wr_end && is_addr && sel_rd) begin
            rd_addr_reg <= AW'(data_s);
         end else if (fetch_ok && is_inc) begin
            rd_addr_reg <= rd_addr_reg + AW'(1);
         end else if (store_ok && is_inc && !dual_address_mode_bit) begin
            rd_addr_reg <= rd_addr_reg + AW'(1);
         end
         if (wr_end && is_addr && sel_wr) begin
            wr_addr_reg <= AW'(data_s);
         end else if (store_ok && is_inc) begin
            wr_addr_reg <= wr_addr_reg + AW'(1);
         end else if (fetch_ok && is_inc && !dual_address_mode_bit) begin
            wr_addr_reg <= wr_addr_reg + AW'(1);
         end
      end
   end

   // ***************************************
   // Data register, host bus and DMA requests
   // ***************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_reg       <= `HPF_DATA_RESET;
         host_data_out  <= 32'h0;
         host_data_oe_n <= 1'b1;
         mem_req        <= 1'b0;
         mem_we         <= 1'b0;
         mem_addr       <= AW'(`HPF_ADDR_RESET);
         mem_wdata      <= 32'h0;
      end else begin
         host_data_oe_n <= ~(cs_low & ctl_reg.rd & (state_next == hpf_pkg::S_HOLD));
         if (start && ctl_reg.rd && is_data) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= rd_addr_reg;
         end else if (wr_end && is_data) begin
            data_reg  <= data_s;
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= wr_addr_reg;
            mem_wdata <= data_s;
         end else if (mem_ack) begin
            mem_req <= 1'b0;
         end
         if (fetch_ok) begin
            data_reg      <= mem_rdata;
            host_data_out <= mem_rdata;
         end else if (start && ctl_reg.rd && is_ctrl) begin
            host_data_out <= ctrl_image;
         end else if (start && ctl_reg.rd && is_addr) begin
            host_data_out <= addr_image;
         end
      end
   end

   // ***************************************
   // Assertions
   // ***************************************
   ready_cs_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cs_low |=> !host_ready) else $error("ready high while deselected");
   reset_stall_a: assert property (@(posedge clk) disable iff (!reset_n)
      (port_reset_bit && cs_low) |=> host_ready) else $error("no stall under port reset");
   deselect_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == hpf_pkg::S_IDLE && !cs_low) |=> state_reg == hpf_pkg::S_IDLE)
      else $error("cycle started while deselected");
   fetch_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      (start && ctl_reg.rd && is_data) |=> mem_req && !mem_we && mem_addr == $past(rd_addr_reg))
      else $error("read fetch wrong");
   read_ready_a: assert property (@(posedge clk) disable iff (!reset_n)
      (fetch_ok && cs_low && !port_reset_bit) |=> !host_ready && host_data_out == $past(mem_rdata))
      else $error("read data not presented");
   write_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_end && is_data) |=> data_reg == $past(data_s)) else $error("write data not captured");
   store_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_end && is_data) |=> mem_req && mem_we && mem_addr == $past(wr_addr_reg))
      else $error("store request wrong");
   wr_autoinc_a: assert property (@(posedge clk) disable iff (!reset_n)
      (store_ok && is_inc) |=> wr_addr_reg == $past(wr_addr_reg) + AW'(1))
      else $error("write address not incremented");
   fixed_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg != hpf_pkg::S_HOLD && ctl_reg.cyc == `HPF_CS_DATA_FIX) |=> $stable(rd_addr_reg))
      else $error("address moved on fixed cycle");
   single_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_end && is_addr && !dual_address_mode_bit) |=> rd_addr_reg == wr_addr_reg)
      else $error("single mode addresses differ");
   ctrl_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_end && is_ctrl) |=> dual_address_mode_bit == $past(data_s[`HPF_CTL_DUAL_BIT]))
      else $error("control write lost");
   as_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      as_fall |=> ctl_reg == $past(pin_ctl_s)) else $error("address strobe latch missed");

   read_cycle_c:  cover property (@(posedge clk) disable iff (!reset_n) fetch_ok ##[1:50] strobe_rise);
   write_cycle_c: cover property (@(posedge clk) disable iff (!reset_n) store_ok);
   ctrl_write_c:  cover property (@(posedge clk) disable iff (!reset_n) wr_end && is_ctrl);
   as_cycle_c:    cover property (@(posedge clk) disable iff (!reset_n) as_fall ##[1:20] strobe_fall);
endmodule // hpf_front
`default_nettype wire

// ---- hdl/hpf_consts.svh ----
// Purpose: Constants for the host port cycle front end
// Assumes: 32-bit word transfers on the host data bus
// Notes:   Bit positions of the control register image
`ifndef HPF_CONSTS_SVH
`define HPF_CONSTS_SVH
// Control register fields
`define HPF_CTL_HALF_BIT      0
`define HPF_CTL_DUAL_BIT      3
`define HPF_CTL_ARWSEL_BIT    4
`define HPF_CTL_RST_BIT       7
`define HPF_CTL_HALF_MIRROR   8
// Reset values
`define HPF_ADDR_RESET        32'h0000_0000
`define HPF_DATA_RESET        32'h0000_0000
// Cycle select codes
`define HPF_CS_CTRL           2'h0
`define HPF_CS_DATA_INC       2'h1
`define HPF_CS_ADDR           2'h2
`define HPF_CS_DATA_FIX       2'h3
`endif

// ---- hdl/hpf_pkg.sv ----
// Purpose: Types for the host port cycle front end
// Assumes: Constants come from hpf_consts.svh
// Notes:   One-hot state codes
`default_nettype none
package hpf_pkg;
   // Front end cycle state
   typedef enum logic [3:0] {
      S_IDLE  = 4'h1,   // Waiting for a strobe
      S_FETCH = 4'h2,   // Memory read in flight
      S_HOLD  = 4'h4,   // Waiting for strobe rise
      S_STORE = 4'h8    // Memory write in flight
   } hpf_state_t;
   // Latched cycle control
   typedef struct packed {
      logic [1:0] cyc;   // Cycle select
      logic       rd;    // High for read
   } hpf_ctl_t;
endpackage
`default_nettype wire

// ---- hdl/hpf_sync.sv ----
// Purpose: Two flip-flop synchroniser for host pins
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage is visible
`default_nettype none
module hpf_sync #(
   parameter int W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_reg;   // First stage, read only by q

   // ***************************************
   // Two stage capture
   // ***************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= INIT;
         q        <= INIT;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // hpf_sync
`default_nettype wire

// ---- testbench/hpf_host_model.sv ----
// Purpose: Host processor model driving the host port pins
// Assumes: Separate active-low read and write strobes, 32-bit words
// Notes:   Pins move only at the falling clock edge
`default_nettype none
module hpf_host_model (
   // Clock and device answers
   input  wire logic        clk,
   input  wire logic        host_ready,
   input  wire logic [31:0] host_data_out,
   input  wire logic        host_data_oe_n,
   // Host pins
   output var  logic        chip_select_n,
   output var  logic        data_strobe_a,
   output var  logic        data_strobe_b,
   output var  logic        addr_strobe_n,
   output var  logic [1:0]  cycle_select,
   output var  logic        read_write_select,
   output var  logic [31:0] host_data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Host bus cycles
   // ****************************************
   // Idle pins: deselected, both strobes high
   initial begin
      chip_select_n = 1'b1;
      data_strobe_a = 1'b1;
      data_strobe_b = 1'b1;
      addr_strobe_n = 1'b1;
      cycle_select = 2'h0;
      read_write_select = 1'b1;
      host_data_in = 32'h0;
   end
   // Set select and strobes directly
   task automatic pins(input logic cs, input logic a, input logic b);
      @(negedge clk);
      chip_select_n = cs;
      data_strobe_a = a;
      data_strobe_b = b;
   endtask
   // One full word cycle; strobe a reads, strobe b writes
   task automatic cycle(input logic [1:0] cyc, input logic rd, input logic [31:0] wd, input logic use_as,
                        output logic [31:0] rdat, output int waits, output logic ok);
      int n;
      waits = 0;
      ok = 1'b0;
      @(negedge clk);
      cycle_select = cyc;
      read_write_select = rd;
      host_data_in = rd ? ~host_data_in : wd;
      chip_select_n = 1'b0;   // select falls with or before the strobe, rises after it
      if (use_as) begin
         addr_strobe_n = 1'b0;
         repeat (4) @(negedge clk);
         cycle_select = ~cyc;   // Stale levels after the latch
         read_write_select = ~rd;
      end
      if (rd) begin
         data_strobe_a = 1'b0;
      end else begin
         data_strobe_b = 1'b0;
      end
      for (n = 0; n < 300 && !ok; n++) begin
         @(negedge clk);
         if (host_ready) waits++;
         else if (n >= 5) ok = 1'b1;
      end
      // Undriven bus reads back broken
      rdat = host_data_oe_n ? ~host_data_out : host_data_out;
      data_strobe_a = 1'b1;
      data_strobe_b = 1'b1;
      repeat (5) @(negedge clk);
      host_data_in = ~host_data_in;   // Released bus
      addr_strobe_n = 1'b1;
      for (n = 0; n < 300; n++) begin
         @(negedge clk);
         if (n >= 4 && !host_ready) break;
      end
      if (n == 300) ok = 1'b0;
      chip_select_n = 1'b1;
   endtask
endmodule // hpf_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the host port front end
// Assumes: Memory model answers after mem_lat cycles
// Notes:   Inputs change at the falling clock edge
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, port_reset_bit, mem_ack, mem_req, mem_we;
   logic cs_n, ds_a, ds_b, as_n, rws, oe_n, rdy, hw_ord, dual, asel;
   logic [1:0] cyc;
   logic [31:0] d_in, d_out, mem_addr, mem_wdata, mem_rdata, rdat, last_addr, last_wdata;
   logic [31:0] mem [logic [31:0]];   // Sparse word memory
   int mem_lat, mem_cnt, waits, n_fail, tests_run;
   hpf_front #(.AW(32)) hpf_front_inst (.clk(clk), .reset_n(reset_n), .chip_select_n(cs_n),
      .data_strobe_a(ds_a), .data_strobe_b(ds_b), .addr_strobe_n(as_n), .cycle_select(cyc),
      .read_write_select(rws), .host_data_in(d_in), .host_data_out(d_out), .host_data_oe_n(oe_n),
      .host_ready(rdy), .port_reset_bit(port_reset_bit), .halfword_order_bit(hw_ord),
      .dual_address_mode_bit(dual), .address_select_bit(asel), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   hpf_host_model hpf_host_model_inst (.clk(clk), .host_ready(rdy), .host_data_out(d_out),
      .host_data_oe_n(oe_n), .chip_select_n(cs_n), .data_strobe_a(ds_a), .data_strobe_b(ds_b),
      .addr_strobe_n(as_n), .cycle_select(cyc), .read_write_select(rws), .host_data_in(d_in));
   // ****************************************
   // Clock and memory model
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Ack pulse after mem_lat cycles; data is garbage outside the ack
   always @(negedge clk) begin
      if (!reset_n) begin
         mem_ack <= 1'b0;
         mem_cnt <= 0;
         mem_rdata <= 32'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            mem_cnt <= mem_cnt + 1;
            if (mem_cnt >= mem_lat) begin
               mem_ack <= 1'b1;
               mem_cnt <= 0;
               last_addr <= mem_addr;
               if (mem_we) begin
                  mem[mem_addr] = mem_wdata;
                  last_wdata <= mem_wdata;
               end else begin
                  mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
               end
            end
         end
      end
   end
   // ****************************************
   // Checking and cycle helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Host cycle; a hang counts as a mismatch
   task automatic hc(input logic [1:0] c, input logic rd, input logic [31:0] wd, input logic use_as);
      logic ok;
      hpf_host_model_inst.cycle(c, rd, wd, use_as, rdat, waits, ok);
      if (!ok) begin
         n_fail++;
         stop_test();
      end
   endtask
   // Reset pulse, then idle outputs
   task automatic do_reset();
      @(negedge clk);
      reset_n = 1'b0;
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      chk({26'h0, rdy, oe_n, mem_req, dual, asel, hw_ord}, 32'h10);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   // Stall while the port reset bit is set; deselect drops ready
   task automatic sc_stall();
      hpf_host_model_inst.pins(1'b0, 1'b0, 1'b1);
      repeat (6) @(negedge clk);
      chk({31'h0, rdy}, 32'h1);
      hpf_host_model_inst.pins(1'b1, 1'b0, 1'b1);
      repeat (5) @(negedge clk);
      chk({31'h0, rdy}, 32'h0);
      hpf_host_model_inst.pins(1'b1, 1'b1, 1'b1);
      port_reset_bit = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   // Control then address setup in single mode
   task automatic sc_setup();
      hc(2'h0, 1'b0, 32'h0000_0001, 1'b0);
      chk({29'h0, asel, dual, hw_ord}, 32'h1);
      hc(2'h0, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h0000_0101);
      hc(2'h2, 1'b0, 32'h0000_0400, 1'b0);
      hc(2'h2, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h0000_0400);
   endtask
   // Data writes and reads with and without increment
   task automatic sc_single();
      hc(2'h1, 1'b0, 32'h1234_5678, 1'b0);
      chk(last_addr, 32'h0000_0400);
      chk(last_wdata, 32'h1234_5678);
      hc(2'h3, 1'b0, 32'h9abc_def0, 1'b0);
      chk(last_addr, 32'h0000_0401);
      hc(2'h3, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h9abc_def0);
      hc(2'h1, 1'b1, 32'h0, 1'b0);
      chk(last_addr, 32'h0000_0401);
      hc(2'h2, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h0000_0402);
   endtask
   // Independent address registers
   task automatic sc_dual();
      mem[32'h0000_0800] = 32'h5a5a_0001;
      hc(2'h0, 1'b0, 32'h0000_0019, 1'b0);
      hc(2'h2, 1'b0, 32'h0000_0800, 1'b0);
      hc(2'h0, 1'b0, 32'h0000_0009, 1'b0);
      hc(2'h2, 1'b0, 32'h0000_0c00, 1'b0);
      hc(2'h1, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h5a5a_0001);
      hc(2'h1, 1'b0, 32'h0f0f_1e1e, 1'b0);
      chk(last_addr, 32'h0000_0c00);
      hc(2'h2, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h0000_0c01);
      hc(2'h0, 1'b0, 32'h0000_0019, 1'b0);
      hc(2'h2, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h0000_0801);
   endtask
   // Early latch on the address strobe; slow memory holds ready
   task automatic sc_as_slow();
      mem[32'h0000_0801] = 32'h3c3c_00ff;
      mem_lat = 20;
      hc(2'h3, 1'b1, 32'h0, 1'b1);
      chk(rdat, 32'h3c3c_00ff);
      chk({31'h0, waits >= 12}, 32'h1);
      mem_lat = 2;
      hc(2'h1, 1'b0, 32'h7777_1111, 1'b1);
      chk(last_addr, 32'h0000_0c01);
      chk(last_wdata, 32'h7777_1111);
   endtask
   // Strobe activity while deselected changes nothing
   task automatic sc_cs_ignore();
      hc(2'h2, 1'b0, 32'h0000_0900, 1'b0);
      hpf_host_model_inst.pins(1'b1, 1'b1, 1'b0);
      repeat (6) @(negedge clk);
      chk({30'h0, rdy, mem_req}, 32'h0);
      hpf_host_model_inst.pins(1'b1, 1'b1, 1'b1);
      repeat (6) @(negedge clk);
      hc(2'h2, 1'b1, 32'h0, 1'b0);
      chk(rdat, 32'h0000_0900);
   endtask
   // Main sequence
   initial begin
      n_fail = 0;
      tests_run = 0;
      mem_lat = 2;
      reset_n = 1'b0;
      port_reset_bit = 1'b1;
      do_reset();
      sc_stall();
      sc_setup();
      sc_single();
      sc_dual();
      sc_as_slow();
      sc_cs_ignore();
      do_reset();
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
